/* File: hdl/mcr_pkg.sv */
/*
  Constants of the monitor control register bank: register offsets, reset
  values, writable-field masks, lockability and field positions.
  Assumes an 8-bit register address and 8-bit register data from the
  serial bus engine.
*/
package mcr_pkg;

  localparam int NUM_REGS = 9;                  // stored control registers

  // index of each stored register in the tables below
  localparam int IDX_GEN   = 0;
  localparam int IDX_OUT   = 1;
  localparam int IDX_GPIO  = 2;
  localparam int IDX_IRQH  = 3;
  localparam int IDX_IRQL  = 4;
  localparam int IDX_CHLO  = 5;
  localparam int IDX_CHHI  = 6;
  localparam int IDX_TEMP  = 7;
  localparam int IDX_REF   = 8;

  // register byte offsets
  localparam logic [7:0] OFS_GENERAL_CONFIGURATION  = 8'h14;
  localparam logic [7:0] OFS_OUTPUT_CONFIGURATION   = 8'h15;
  localparam logic [7:0] OFS_GPIO_PULLDOWN_CONTROL  = 8'h16;
  localparam logic [7:0] OFS_HIGH_LIMIT_IRQ_ENABLE  = 8'h17;
  localparam logic [7:0] OFS_LOW_LIMIT_IRQ_ENABLE   = 8'h18;
  localparam logic [7:0] OFS_CHANNEL_ENABLE_LOW     = 8'h19;
  localparam logic [7:0] OFS_CHANNEL_ENABLE_HIGH    = 8'h1A;
  localparam logic [7:0] OFS_TEMP_CHANNEL_ENABLE    = 8'h1B;
  localparam logic [7:0] OFS_SINGLE_SHOT_TRIGGER    = 8'h1C;
  localparam logic [7:0] OFS_REFERENCE_MODE         = 8'h66;

  localparam logic [7:0] REG_OFS [NUM_REGS] = '{
    OFS_GENERAL_CONFIGURATION, OFS_OUTPUT_CONFIGURATION, OFS_GPIO_PULLDOWN_CONTROL,
    OFS_HIGH_LIMIT_IRQ_ENABLE, OFS_LOW_LIMIT_IRQ_ENABLE, OFS_CHANNEL_ENABLE_LOW,
    OFS_CHANNEL_ENABLE_HIGH, OFS_TEMP_CHANNEL_ENABLE, OFS_REFERENCE_MODE};

  // power-on values
  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    8'h00, 8'h03, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07};

  // writable bits; other bits hold their power-on value
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    8'h07, 8'h07, 8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'h01, 8'h06};

  // registers frozen by the lock bit
  localparam bit REG_LOCKABLE [NUM_REGS] = '{
    1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  localparam bit TRIG_LOCKABLE = 1'b1;          // trigger register flag; the lock bit does not freeze trigger writes

  // field positions
  localparam int GEN_SOFT_RESET_BIT = 7;
  localparam int GEN_TIMEOUT_DIS_BIT = 2;
  localparam int GEN_LOCK_BIT       = 1;
  localparam int GEN_START_BIT      = 0;
  localparam int OUT_GROUPING_BIT   = 2;
  localparam int OUT_LEVEL_BIT      = 1;
  localparam int OUT_HIZ_BIT        = 0;
  localparam int REF_ADC_EXT_BIT    = 2;
  localparam int REF_DAC_EXT_BIT    = 1;
  localparam int TEMP_ENABLE_BIT    = 0;
  localparam int IRQ_EN_W           = 6;
  localparam int CH_EN_W            = 17;

  localparam logic [7:0] RDATA_NONE = 8'h00;    // unmapped and write-only reads

  // address decode shared by every register
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

endpackage : mcr_pkg

/* File: hdl/mcr_wr_if.sv */
/*
  Write path shared by the register bank and its register cells.
  Assumes a single clock domain; all members are driven by the top.
*/
`timescale 1ns/1ns
`default_nettype none

interface mcr_wr_if;
  logic       wr_stb;       // one-cycle write strobe
  logic [7:0] wr_addr;      // register offset
  logic [7:0] wr_data;      // write data
  logic       soft_rst;     // soft reset, same cycle as its write
  logic       lock;         // current lock bit

  modport source (output wr_stb, output wr_addr, output wr_data, output soft_rst, output lock);
  modport sink   (input wr_stb, input wr_addr, input wr_data, input soft_rst, input lock);
endinterface : mcr_wr_if

`default_nettype wire

/* File: hdl/mcr_reg_cell.sv */
/*
  One 8-bit control register with power-on value, writable-bit mask and
  optional lock protection.
  Assumes the write path interface is driven on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module mcr_reg_cell
  import mcr_pkg::*;
#(
  parameter logic [7:0] OFFSET     = 8'h00,
  parameter logic [7:0] RESET_VAL  = 8'h00,
  parameter logic [7:0] FIELD_MASK = 8'hFF,
  parameter bit         LOCKABLE   = 1'b0
) (
  input  wire logic   clk_sys_i,   // system clock
  input  wire logic   rst_i,       // synchronous reset
  mcr_wr_if.sink      bus,         // write path
  output logic [7:0]  value_o      // register contents
);

  logic [7:0] value_r;
  logic       wr_ok;

  // write accepted unless the register is frozen
  assign wr_ok = bus.wr_stb && reg_hit(bus.wr_addr, OFFSET) && !(LOCKABLE && bus.lock);

  // soft reset beats any write; reserved bits keep their power-on value
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || bus.soft_rst) begin
      value_r <= RESET_VAL;
    end else if (wr_ok) begin
      value_r <= (bus.wr_data & FIELD_MASK) | (RESET_VAL & ~FIELD_MASK);
    end
  end

  assign value_o = value_r;

endmodule : mcr_reg_cell

`default_nettype wire

/* File: hdl/mcr_conv_ctrl.sv */
/*
  Conversion start control: holds a single-shot request and issues it as a
  one-cycle start pulse once locked and the converter is idle; drives the
  continuous-run level.
  Assumes the sequencer idle flag is on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module mcr_conv_ctrl
  import mcr_pkg::*;
(
  input  wire logic clk_sys_i,       // system clock
  input  wire logic rst_i,           // synchronous reset
  mcr_wr_if.sink    bus,             // write path
  input  wire logic cont_start_i,    // continuous-start bit
  input  wire logic adc_idle_i,      // sequencer idle
  output logic      single_start_o,  // single pass start pulse
  output logic      cont_run_o,      // continuous conversion level
  output logic      pending_o        // single pass waiting
);

  typedef enum {CV_IDLE, CV_PENDING} mcr_conv_state_t;

  mcr_conv_state_t state_r;
  logic            trig_wr;
  logic            single_start_r;
  logic            cont_run_r;

  // any value written while continuous mode is off asks for one pass
  assign trig_wr = bus.wr_stb && reg_hit(bus.wr_addr, OFS_SINGLE_SHOT_TRIGGER) && !cont_start_i;

  // request state; cleared by reset, soft reset, continuous mode or issuing its start pulse
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || bus.soft_rst) begin
      state_r <= CV_IDLE;
    end else begin
      case (state_r)
        CV_IDLE: begin
          if (trig_wr) begin
            state_r <= CV_PENDING;
          end
        end
        CV_PENDING: begin
          if (cont_start_i) begin
            state_r <= CV_IDLE;
          end else if (bus.lock && adc_idle_i) begin
            state_r <= CV_IDLE;
          end
        end
        default: state_r <= CV_IDLE;
      endcase
    end
  end

  // start pulse leaves with the pending state
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || bus.soft_rst) begin
      single_start_r <= 1'b0;
    end else begin
      single_start_r <= (state_r == CV_PENDING) && !cont_start_i && bus.lock && adc_idle_i;
    end
  end

  // continuous run only while locked
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || bus.soft_rst) begin
      cont_run_r <= 1'b0;
    end else begin
      cont_run_r <= cont_start_i && bus.lock;
    end
  end

  assign single_start_o = single_start_r;
  assign cont_run_o     = cont_run_r;
  assign pending_o      = (state_r == CV_PENDING);

endmodule : mcr_conv_ctrl

`default_nettype wire

/* File: hdl/mcr_regbank.sv */
/*
  Control register bank of an analog monitor and controller. Holds the
  general, output, GPIO pulldown, interrupt enable, channel enable,
  single-shot trigger and reference mode registers and drives their
  fields to the rest of the device.
  Assumes the serial bus engine on the same clock presents one-cycle read
  and write strobes with an 8-bit offset and 8-bit data.
*/
//
// Operation
// - writing 1 to general bit 7 restores every register to power-on value
// - general bit 2 set disables the serial bus timeout
// - lock bit freezes lockable registers against later bus writes
// - general bit 0 starts continuous conversion; clearing it stops it
// - conversions begin only while the lock bit is set
// - any trigger write with continuous start clear asks one single pass
// - output bit 2 selects grouping of outputs with control inputs
// - output bit 1 selects forced level: 1 supply rail, 0 ground
// - output bit 0 places all twelve outputs in high impedance
// - output configuration resets to 0x03
// - GPIO bit n set turns pulldown of pin n off; resets 0xFF
// - high-limit enables bits 0..5 for channels 1,2,3,9,10,11
// - low-limit enables bits 0..5 for channels 1,2,3,9,10,11
// - first channel enable bits 0..7 enable channels 1 to 8
// - second channel enable bits 0..7 enable channels 9 to 16
// - third channel enable bit 0 enables the temperature channel
// - reference bit 2 selects ADC external reference
// - reference bit 1 selects DAC external reference; resets 0x07
`timescale 1ns/1ns
`default_nettype none

module mcr_regbank
  import mcr_pkg::*;
(
  input  wire logic                clk_sys_i,                 // system clock, 25 MHz
  input  wire logic                rst_i,                     // synchronous reset, active high
  input  wire logic                reg_wr_i,                  // write strobe from bus engine
  input  wire logic                reg_rd_i,                  // read strobe from bus engine
  input  wire logic [7:0]          reg_addr_i,                // register offset
  input  wire logic [7:0]          reg_wdata_i,               // write data
  input  wire logic                adc_idle_i,                // sequencer idle
  output logic      [7:0]          reg_rdata_o,               // read data
  output logic                     reg_rvalid_o,              // read data valid pulse
  output logic                     write_refused_o,           // write ignored pulse
  output logic                     soft_reset_o,              // soft reset pulse to other blocks
  output logic                     bus_timeout_disable_o,     // bus timeout off
  output logic                     lock_o,                    // lock bit
  output logic                     continuous_run_o,          // continuous conversion
  output logic                     single_shot_start_o,       // single pass start pulse
  output logic                     single_shot_pending_o,     // single pass waiting
  output logic                     output_grouping_select_o,  // output grouping
  output logic                     forced_level_select_o,     // forced level
  output logic                     outputs_hiz_o,             // outputs high impedance
  output logic      [7:0]          pulldown_off_o,            // GPIO pulldowns off
  output logic      [IRQ_EN_W-1:0] high_irq_enable_o,         // high-limit irq enables
  output logic      [IRQ_EN_W-1:0] low_irq_enable_o,          // low-limit irq enables
  output logic      [CH_EN_W-1:0]  channel_enable_o,          // channel 1..16, temp at 16
  output logic                     adc_external_reference_o,  // ADC external reference
  output logic                     dac_external_reference_o   // DAC external reference
);

  mcr_wr_if wbus ();

  logic [7:0] reg_val [NUM_REGS];
  logic [7:0] rdata_nxt;
  logic       mapped_wr;
  logic       frozen_wr;
  logic       trig_frozen;
  logic [7:0] rdata_r;
  logic       rvalid_r;
  logic       refused_r;
  logic       soft_reset_r;
  logic       cont_run;
  logic       single_start;
  logic       single_pending;

  // write path; soft reset acts in the cycle of its write
  assign wbus.wr_stb   = reg_wr_i;
  assign wbus.wr_addr  = reg_addr_i;
  assign wbus.wr_data  = reg_wdata_i;
  assign wbus.soft_rst = reg_wr_i && reg_hit(reg_addr_i, OFS_GENERAL_CONFIGURATION)
                         && reg_wdata_i[GEN_SOFT_RESET_BIT];
  assign wbus.lock     = reg_val[IDX_GEN][GEN_LOCK_BIT];

  // stored control registers
  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      mcr_reg_cell #(
        .OFFSET     (REG_OFS[i]),
        .RESET_VAL  (REG_RST[i]),
        .FIELD_MASK (REG_MASK[i]),
        .LOCKABLE   (REG_LOCKABLE[i])
      ) u_cell (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .bus       (wbus.sink),
        .value_o   (reg_val[i])
      );
    end
  endgenerate

  // conversion start control
  mcr_conv_ctrl u_conv (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .bus            (wbus.sink),
    .cont_start_i   (reg_val[IDX_GEN][GEN_START_BIT]),
    .adc_idle_i     (adc_idle_i),
    .single_start_o (single_start),
    .cont_run_o     (cont_run),
    .pending_o      (single_pending)
  );

  // classify writes that change nothing
  always_comb begin
    mapped_wr = reg_hit(reg_addr_i, OFS_SINGLE_SHOT_TRIGGER);
    frozen_wr = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (reg_hit(reg_addr_i, REG_OFS[i])) begin
        mapped_wr = 1'b1;
        frozen_wr = REG_LOCKABLE[i] && wbus.lock;
      end
    end
  end

  // a trigger write during continuous mode is ignored
  assign trig_frozen = reg_hit(reg_addr_i, OFS_SINGLE_SHOT_TRIGGER)
                       && reg_val[IDX_GEN][GEN_START_BIT];

  // refused-write pulse
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= reg_wr_i && !wbus.soft_rst && (!mapped_wr || frozen_wr || trig_frozen);
    end
  end

  // soft reset pulse, one cycle after its write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= wbus.soft_rst;
    end
  end

  // read mux; soft reset bit and trigger read as zero
  always_comb begin
    rdata_nxt = RDATA_NONE;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (reg_hit(reg_addr_i, REG_OFS[i])) begin
        rdata_nxt = reg_val[i];
      end
    end
  end

  // registered read answer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_r  <= RDATA_NONE;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // general configuration fields
  assign bus_timeout_disable_o = reg_val[IDX_GEN][GEN_TIMEOUT_DIS_BIT];
  assign lock_o                = reg_val[IDX_GEN][GEN_LOCK_BIT];
  assign continuous_run_o      = cont_run;
  assign single_shot_start_o   = single_start;
  assign single_shot_pending_o = single_pending;

  // output configuration fields
  assign output_grouping_select_o = reg_val[IDX_OUT][OUT_GROUPING_BIT];
  assign forced_level_select_o    = reg_val[IDX_OUT][OUT_LEVEL_BIT];
  assign outputs_hiz_o            = reg_val[IDX_OUT][OUT_HIZ_BIT];

  // GPIO pulldown control
  assign pulldown_off_o = reg_val[IDX_GPIO];

  // limit interrupt enables, channels 1,2,3,9,10,11 in bits 0..5
  assign high_irq_enable_o = reg_val[IDX_IRQH][IRQ_EN_W-1:0];
  assign low_irq_enable_o  = reg_val[IDX_IRQL][IRQ_EN_W-1:0];

  // channel enables; temperature channel on top
  assign channel_enable_o = {reg_val[IDX_TEMP][TEMP_ENABLE_BIT],
                             reg_val[IDX_CHHI],
                             reg_val[IDX_CHLO]};

  // reference selects
  assign adc_external_reference_o = reg_val[IDX_REF][REF_ADC_EXT_BIT];
  assign dac_external_reference_o = reg_val[IDX_REF][REF_DAC_EXT_BIT];

  // bus answers
  assign reg_rdata_o     = rdata_r;
  assign reg_rvalid_o    = rvalid_r;
  assign write_refused_o = refused_r;
  assign soft_reset_o    = soft_reset_r;

endmodule : mcr_regbank

`default_nettype wire

/* File: dv/mcr_regbank_monitor.sv */
/*
  Concurrent checks on the control register bank ports.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module mcr_regbank_monitor
  import mcr_pkg::*;
(
  input wire logic               clk_sys_i,                 // clock
  input wire logic               rst_i,                     // reset
  input wire logic               reg_wr_i,                  // write strobe
  input wire logic               reg_rd_i,                  // read strobe
  input wire logic [7:0]         reg_addr_i,                // offset
  input wire logic [7:0]         reg_wdata_i,               // write data
  input wire logic               adc_idle_i,                // idle
  input wire logic               reg_rvalid_o,              // read valid
  input wire logic               write_refused_o,           // refused
  input wire logic               soft_reset_o,              // soft reset
  input wire logic               bus_timeout_disable_o,     // timeout off
  input wire logic               lock_o,                    // lock
  input wire logic               continuous_run_o,          // continuous
  input wire logic               single_shot_start_o,       // start
  input wire logic               single_shot_pending_o,     // pending
  input wire logic               output_grouping_select_o,  // grouping
  input wire logic               forced_level_select_o,     // level
  input wire logic               outputs_hiz_o,             // hiz
  input wire logic [7:0]         pulldown_off_o,            // pulldowns
  input wire logic [CH_EN_W-1:0] channel_enable_o,          // channels
  input wire logic               adc_external_reference_o,  // adc ref
  input wire logic               dac_external_reference_o   // dac ref
);
  // write decodes per register
  wire wr_gen = reg_wr_i && (reg_addr_i == 8'h14);
  wire wr_lck = reg_wr_i && (reg_addr_i >= 8'h17) && (reg_addr_i <= 8'h1B);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  a_read_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("valid without read");
  a_soft_reset: assert property (wr_gen && reg_wdata_i[7] |=> soft_reset_o && !lock_o && outputs_hiz_o
    && forced_level_select_o && pulldown_off_o == 8'hFF && channel_enable_o == '0) else $error("soft reset");
  a_lock_freeze: assert property (lock_o && wr_lck |=> write_refused_o && $stable(channel_enable_o))
    else $error("locked write took effect");
  a_gen_fields: assert property (wr_gen && !reg_wdata_i[7] |=> bus_timeout_disable_o == $past(reg_wdata_i[2])
    && lock_o == $past(reg_wdata_i[1])) else $error("general fields");
  a_out_fields: assert property (reg_wr_i && reg_addr_i == 8'h15 |=>
    {output_grouping_select_o, forced_level_select_o, outputs_hiz_o} == $past(reg_wdata_i[2:0]))
    else $error("output fields");
  a_ref_fields: assert property (reg_wr_i && reg_addr_i == 8'h66 |=>
    {adc_external_reference_o, dac_external_reference_o} == $past(reg_wdata_i[2:1])) else $error("ref fields");
  a_gpio_field: assert property (reg_wr_i && reg_addr_i == 8'h16 |=> pulldown_off_o == $past(reg_wdata_i))
    else $error("pulldown field");
  a_chan_low: assert property (!lock_o && reg_wr_i && reg_addr_i == 8'h19 |=>
    channel_enable_o[7:0] == $past(reg_wdata_i)) else $error("channel low field");
  a_start_cause: assert property (single_shot_start_o |-> $past(single_shot_pending_o) && $past(lock_o)
    && $past(adc_idle_i) ##1 !single_shot_start_o) else $error("start without cause");
  a_cont_lock: assert property (continuous_run_o |-> $past(lock_o)) else $error("continuous unlocked");

  // main scenarios reached
  c_start: cover property (single_shot_start_o);
  c_locked_write: cover property (lock_o && wr_lck);
  c_soft_reset: cover property (soft_reset_o);
endmodule : mcr_regbank_monitor

bind mcr_regbank mcr_regbank_monitor i_mcr_regbank_monitor (.*);

`default_nettype wire

/* File: dv/mcr_seq_model.sv */
/*
  Conversion sequencer stand-in: busy for a few cycles after each start.
  Assumes the start pulse is one cycle long on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module mcr_seq_model #(
  parameter int BUSY_CYC = 6
) (
  input  wire logic clk_sys_i,  // clock
  input  wire logic rst_i,      // reset
  input  wire logic start_i,    // pass start
  output logic      idle_o      // sequencer idle
);
  logic [3:0] busy_cnt_r;

  // count down the pass so back-to-back requests must wait
  always_ff @(posedge clk_sys_i) begin
    if (rst_i)
      busy_cnt_r <= 4'h0;
    else if (start_i)
      busy_cnt_r <= 4'(BUSY_CYC);
    else if (busy_cnt_r != 4'h0)
      busy_cnt_r <= busy_cnt_r - 4'h1;
  end

  assign idle_o = (busy_cnt_r == 4'h0);
endmodule : mcr_seq_model

`default_nettype wire

/* File: dv/test_monitor_control_register_bank.sv */
/*
  Self-checking bench for the control register bank.
  Assumes a 25 MHz clock and register access by one-cycle strobes.
*/
`timescale 1ns/1ns
`default_nettype none

module test_monitor_control_register_bank;
  import mcr_pkg::*;
  logic clk_sys_i, rst_i, reg_wr_i, reg_rd_i, adc_idle_i, reg_rvalid_o, write_refused_o, soft_reset_o;
  logic bus_timeout_disable_o, lock_o, continuous_run_o, single_shot_start_o, single_shot_pending_o;
  logic output_grouping_select_o, forced_level_select_o, outputs_hiz_o;
  logic adc_external_reference_o, dac_external_reference_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pulldown_off_o;
  logic [IRQ_EN_W-1:0] high_irq_enable_o, low_irq_enable_o;
  logic [CH_EN_W-1:0] channel_enable_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_start = 0;
  int s0;
  localparam logic [7:0] OFS_T [11] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h66, 8'h20};
  localparam logic [7:0] RST_T [11] = '{8'h00, 8'h03, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
  localparam logic [7:0] MAX_T [11] = '{8'h00, 8'h07, 8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'h01, 8'h00, 8'h07, 8'h00};

  mcr_regbank i_mcr_regbank (.*);
  mcr_seq_model i_mcr_seq_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(single_shot_start_o),
    .idle_o(adc_idle_i));

  task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rvalid", reg_rvalid_o, 17'h00001);
    chk($sformatf("reg %0h", a), reg_rdata_o, e);
  endtask : rd

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // start pulses seen by the sequencer side
  always @(posedge clk_sys_i) begin
    if (single_shot_start_o === 1'b1) n_start++;
  end

  // watchdog
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    n_mismatch++;
    finish_test();
  end

  initial begin
    rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // power-on values, write-only and unmapped reads
    foreach (OFS_T[i]) rd(OFS_T[i], RST_T[i]);
    $display("test reset values done");
    // all ones then all zeros; reserved bits keep their value
    for (int i = 1; i < 11; i++) if (i != 8) wr(OFS_T[i], 8'hFF);
    for (int i = 1; i < 11; i++) rd(OFS_T[i], MAX_T[i]);
    chk("chen", channel_enable_o, 17'h1FFFF);
    chk("hie", high_irq_enable_o, 17'h0003F);
    chk("lie", low_irq_enable_o, 17'h0003F);
    for (int i = 1; i < 11; i++) if (i != 8) wr(OFS_T[i], 8'h00);
    for (int i = 1; i < 11; i++) rd(OFS_T[i], (i == 9) ? 8'h01 : 8'h00);
    $display("test field masks done");
    // bit positions of each field
    wr(8'h19, 8'h01);
    wr(8'h1A, 8'h80);
    wr(8'h1B, 8'h01);
    chk("chen", channel_enable_o, 17'h18001);
    wr(8'h17, 8'h21);
    chk("hie", high_irq_enable_o, 17'h00021);
    wr(8'h18, 8'h12);
    chk("lie", low_irq_enable_o, 17'h00012);
    wr(8'h15, 8'h04);
    chk("refused", write_refused_o, 17'h0);
    chk("outcfg", {output_grouping_select_o, forced_level_select_o, outputs_hiz_o}, 17'h4);
    wr(8'h15, 8'h03);
    chk("outcfg", {output_grouping_select_o, forced_level_select_o, outputs_hiz_o}, 17'h3);
    wr(8'h66, 8'h04);
    chk("ref", {adc_external_reference_o, dac_external_reference_o}, 17'h2);
    wr(8'h66, 8'h02);
    chk("ref", {adc_external_reference_o, dac_external_reference_o}, 17'h1);
    wr(8'h14, 8'h04);
    chk("tod", bus_timeout_disable_o, 17'h1);
    chk("softrst", soft_reset_o, 17'h0);
    rd(8'h14, 8'h04);
    $display("test field mapping done");
    // unlocked trigger waits for the lock
    wr(8'h14, 8'h00);
    s0 = n_start;
    wr(8'h1C, 8'h00);
    repeat (10) @(posedge clk_sys_i);
    chk("pend", single_shot_pending_o, 17'h1);
    chk("starts", 17'(n_start - s0), 17'h0);
    wr(8'h14, 8'h02);
    wr(8'h19, 8'h55);
    chk("refused", write_refused_o, 17'h1);
    rd(8'h19, 8'h01);
    // back-to-back triggers while locked: second lands while pending and merges
    wr(8'h1C, 8'h5A);
    wr(8'h1C, 8'hA5);
    repeat (20) @(posedge clk_sys_i);
    chk("starts", 17'(n_start - s0), 17'h2);
    $display("test lock and single shot done");
    // continuous mode refuses triggers
    wr(8'h14, 8'h03);
    repeat (2) @(posedge clk_sys_i);
    chk("cont", continuous_run_o, 17'h1);
    wr(8'h1C, 8'h00);
    chk("refused", write_refused_o, 17'h1);
    repeat (3) @(posedge clk_sys_i);
    chk("pend", single_shot_pending_o, 17'h0);
    wr(8'h14, 8'h02);
    repeat (2) @(posedge clk_sys_i);
    chk("cont", continuous_run_o, 17'h0);
    $display("test continuous done");
    // soft reset restores everything, itself included
    wr(8'h16, 8'h0F);
    chk("pulldown", pulldown_off_o, 17'h0000F);
    wr(8'h14, 8'h86);
    chk("softrst", soft_reset_o, 17'h1);
    chk("lock", lock_o, 17'h0);
    chk("pulldown", pulldown_off_o, 17'h000FF);
    rd(8'h14, 8'h00);
    rd(8'h16, 8'hFF);
    rd(8'h1A, 8'h00);
    $display("test soft reset done");
    finish_test();
  end
endmodule : test_monitor_control_register_bank

`default_nettype wire
